// >>> logic/pdca_pkg.sv
// package: constants, layouts and states for the capability advertiser
package pdca_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CFG = 12'h004;
    localparam logic [11:0] OFS_PDO1 = 12'h008;
    localparam logic [11:0] OFS_STAT = 12'h00C;
    localparam logic [11:0] OFS_HDR = 12'h010;
    // object type codes in bits 31..30
    localparam logic [1:0] TYPE_FIXED = 2'h0;
    localparam logic [1:0] TYPE_BATTERY = 2'h1;
    localparam logic [1:0] TYPE_VARIABLE = 2'h2;
    localparam logic [1:0] TYPE_RESERVED = 2'h3;
    // fixed object field positions
    localparam int POS_TYPE = 30;
    localparam int POS_DRP = 29;
    localparam int POS_SUSP = 28;
    localparam int POS_EXTP = 27;
    localparam int POS_COMM = 26;
    localparam int POS_DRSWAP = 25;
    localparam int POS_PEAK = 20;
    localparam int POS_VOLT = 10;
    localparam int POS_CURR = 0;
    // 5 V in 50 mV steps
    localparam logic [9:0] VOLT_5V = 10'h064;
    localparam logic [9:0] CURR_0MA = 10'h000;
    // message types
    localparam logic [3:0] MSG_SRC_CAP = 4'h1;
    localparam logic [3:0] MSG_SNK_CAP = 4'h4;
    localparam logic [3:0] MSG_HARD_RESET = 4'hF;
    localparam logic [3:0] MSG_WAIT = 4'hC;
    localparam logic [3:0] MSG_GOTOMIN = 4'h2;
    // timing, milliseconds
    localparam int SRC_CAP_TIMER_MS = 150;
    localparam int SNK_WAIT_CAP_MS = 465;
    localparam int PS_SOURCE_OFF_MS = 750;
    localparam int CLK_MHZ = 250;
    localparam int SRC_CAP_CYC = SRC_CAP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int SNK_WAIT_CYC = SNK_WAIT_CAP_MS * 1000 * CLK_MHZ;
    localparam int PS_OFF_CYC = PS_SOURCE_OFF_MS * 1000 * CLK_MHZ;
    localparam int N_CAPS_COUNT = 50;
    localparam logic [5:0] CAPS_COUNT_W = 6'(N_CAPS_COUNT);
    localparam logic [31:0] RST_PDO1 = 32'h0001_9000;
    typedef enum logic [2:0] {
        PDCA_IDLE, PDCA_ADV_WAIT, PDCA_ADV_SEND, PDCA_ADV_ACK, PDCA_DONE
    } pdca_adv_e;
endpackage

// >>> logic/pdca_top.sv
// capability advertiser: message scheduling, fixed object build and APB registers
// Functional notes
// - after reset, power-on or attach, source advertises capabilities at each timer expiry
// - advertising repeats at least the count and stops on acknowledgement
// - otherwise capabilities go out only on supply change or capability query
// - a sink answers every sink capability query with its capabilities
// - sink seeing 5 V but no capabilities before timeout sends hard reset
// - dual role answers both queries in any role, advertises only as source
// - capabilities are 32-bit objects; one object is sent, header count is two with reserve
// - every source capability message holds one 5 V object at least
// - allocated reserve is included in every source capability message; sink capability replies count one
// - a received goto-min message, as source or dual role, only triggers a resend of capabilities
// - reserve withdrawal is announced with a new capability message
// - dual-role source receiving unexpected capabilities removes 5 V within the off time
// - fixed objects carry type code zero in the top two bits
// - peak at 21..20, voltage 19..10, max current 9..0
// - only the 5 V object carries the five flag bits 29..25
// - other fixed objects zero bits 29..22; bits 24..22 always zero
// - no capability means 5 V with 0 mA
// - forcing the sink to its lowest state advertises 5 V with 0 mA
// - dual role flag follows swap support and is locked after its first write after reset
// - object type codes: fixed, battery, variable, reserved
`timescale 1ns/1ps
module pdca_top #(
    parameter int SRC_CAP_CYC = pdca_pkg::SRC_CAP_CYC,
    parameter int SNK_WAIT_CYC = pdca_pkg::SNK_WAIT_CYC,
    parameter int PS_OFF_CYC = pdca_pkg::PS_OFF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic attach,
    input wire logic vbus_5v,
    input wire logic rx_valid,
    input wire logic [3:0] rx_type,
    input wire logic rx_src_cap,
    input wire logic rx_goodcrc,
    input wire logic tx_done,
    output logic tx_req,
    output logic [3:0] tx_type,
    output logic [2:0] tx_count,
    output logic [31:0] tx_pdo,
    output logic vbus_off
);
    typedef struct packed {
        logic [2:0] att_s;
        logic [2:0] vb_s;
        pdca_pkg::pdca_adv_e adv;
        logic [31:0] tmr;
        logic [5:0] sent;
        logic [31:0] wtmr;
        logic wait_done;
        logic [31:0] otmr;
        logic off_run;
        logic vbus_off;
        logic role_src;
        logic dual_role;
        logic drp_lock;
        logic sink_port;
        logic [1:0] pend;
        logic [31:0] pdo1;
        logic [2:0] n_obj;
        logic reserve;
        logic susp_force;
        logic resend;
        logic query_pend;
        logic tx_req;
        logic [3:0] tx_type;
        logic [2:0] tx_count;
        logic [31:0] tx_pdo;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pdca_state_s;

    pdca_state_s st_reg, st_next;

    // fixed object builder: flags only on the 5 V object
    function automatic logic [31:0] pdca_fixed(input logic [31:0] cfg, input logic is_5v,
            input logic drp, input logic zero_i);
        logic [31:0] o;
        o = 32'h0000_0000;
        o[31:30] = pdca_pkg::TYPE_FIXED;
        o[21:20] = cfg[21:20];
        o[19:10] = is_5v ? pdca_pkg::VOLT_5V : cfg[19:10];
        o[9:0] = zero_i ? pdca_pkg::CURR_0MA : cfg[9:0];
        if (is_5v) begin
            o[29] = drp;
            o[28:25] = cfg[28:25];
        end
        return o; // bits 24..22 stay zero
    endfunction

    logic wr, is_src_cap_q;
    assign wr = psel && penable && pwrite;
    assign is_src_cap_q = rx_valid && (rx_type == pdca_pkg::MSG_SRC_CAP);

    always_comb begin
        st_next = st_reg;
        st_next.att_s = {st_reg.att_s[1:0], attach};
        st_next.vb_s = {st_reg.vb_s[1:0], vbus_5v};
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        // registers: data and error are set up here so they stand together with ready
        if (psel && !penable) begin
            st_next.pready = 1'b1;
            if (pwrite) begin
                st_next.pslverr = !(paddr == pdca_pkg::OFS_CTRL || paddr == pdca_pkg::OFS_CFG
                    || paddr == pdca_pkg::OFS_PDO1);
            end else begin
                case (paddr)
                    pdca_pkg::OFS_CTRL: st_next.prdata = {28'h0, st_reg.susp_force,
                        st_reg.reserve, st_reg.sink_port, st_reg.role_src};
                    pdca_pkg::OFS_CFG: st_next.prdata = {30'h0, st_reg.drp_lock,
                        st_reg.dual_role};
                    pdca_pkg::OFS_PDO1: st_next.prdata = st_reg.pdo1;
                    pdca_pkg::OFS_STAT: st_next.prdata = {20'h0, st_reg.vbus_off,
                        st_reg.wait_done, st_reg.sent, 1'b0, st_reg.adv};
                    pdca_pkg::OFS_HDR: st_next.prdata = {29'h0, st_reg.n_obj};
                    default: begin
                        st_next.prdata = 32'h0000_0000;
                        st_next.pslverr = 1'b1;
                    end
                endcase
            end
        end
        if (wr && st_reg.pready) begin
            case (paddr)
                pdca_pkg::OFS_CTRL: begin
                    st_next.role_src = pwdata[0];
                    st_next.sink_port = pwdata[1];
                    st_next.reserve = pwdata[2];
                    st_next.susp_force = pwdata[3];
                    if (pwdata[4]) begin
                        st_next.resend = 1'b1;
                    end
                    if (st_reg.reserve && !pwdata[2]) begin
                        st_next.resend = 1'b1;
                    end
                end
                pdca_pkg::OFS_CFG: begin
                    if (!st_reg.drp_lock) begin
                        st_next.dual_role = pwdata[0];
                        st_next.drp_lock = 1'b1;
                    end
                end
                pdca_pkg::OFS_PDO1: begin
                    st_next.pdo1 = pwdata;
                    st_next.resend = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // one 5 V object; reserve raises the count to two without a second entry
        st_next.n_obj = st_reg.reserve ? 3'h2 : 3'h1;
        // advertisement cycle
        case (st_reg.adv)
            pdca_pkg::PDCA_IDLE: begin
                if (st_reg.att_s[2] && st_reg.role_src) begin
                    st_next.adv = pdca_pkg::PDCA_ADV_WAIT;
                    st_next.tmr = 32'h0;
                    st_next.sent = 6'h0;
                end
            end
            pdca_pkg::PDCA_ADV_WAIT: begin
                // the acknowledgement may trail the end of transmission into the wait
                if (rx_goodcrc) begin
                    st_next.adv = pdca_pkg::PDCA_DONE;
                end else if (st_reg.tmr >= 32'(SRC_CAP_CYC - 1)) begin
                    st_next.adv = pdca_pkg::PDCA_ADV_SEND;
                end else begin
                    st_next.tmr = st_reg.tmr + 32'h1;
                end
            end
            pdca_pkg::PDCA_ADV_SEND: begin
                if (!st_reg.tx_req) begin
                    st_next.pend = 2'h1;
                    st_next.adv = pdca_pkg::PDCA_ADV_ACK;
                end
            end
            pdca_pkg::PDCA_ADV_ACK: begin
                if (rx_goodcrc) begin
                    st_next.adv = pdca_pkg::PDCA_DONE;
                end else if (tx_done) begin
                    st_next.tmr = 32'h0;
                    st_next.sent = (st_reg.sent == 6'h3F) ? st_reg.sent : st_reg.sent + 6'h1;
                    st_next.adv = pdca_pkg::PDCA_ADV_WAIT;
                end
            end
            pdca_pkg::PDCA_DONE: begin
            end
            default: st_next.adv = pdca_pkg::PDCA_IDLE;
        endcase
        if (!st_reg.att_s[2] || !st_reg.role_src) begin
            st_next.adv = pdca_pkg::PDCA_IDLE;
        end
        // sink wait for capabilities
        if (st_reg.role_src || !st_reg.vb_s[2] || (rx_valid && rx_src_cap)) begin
            st_next.wtmr = 32'h0;
            st_next.wait_done = 1'b0;
        end else if (!st_reg.wait_done) begin
            if (st_reg.wtmr >= 32'(SNK_WAIT_CYC - 1)) begin
                st_next.wait_done = 1'b1;
                st_next.pend = 2'h3;
            end else begin
                st_next.wtmr = st_reg.wtmr + 32'h1;
            end
        end
        // replies to queries
        if (is_src_cap_q && st_reg.role_src && st_reg.dual_role) begin
            st_next.off_run = 1'b1;
        end
        if (rx_valid && rx_type == pdca_pkg::MSG_SNK_CAP) begin
            if (!st_reg.role_src || st_reg.dual_role || st_reg.sink_port) begin
                st_next.pend = 2'h2;
            end
        end
        if (rx_valid && rx_type == pdca_pkg::MSG_GOTOMIN) begin
            if (st_reg.role_src || st_reg.dual_role) begin
                st_next.query_pend = 1'b1;
            end
        end
        if (st_reg.resend && st_reg.role_src && st_reg.pend == 2'h0 && !st_reg.tx_req) begin
            st_next.resend = 1'b0;
            st_next.pend = 2'h1;
        end
        if (st_reg.query_pend && st_reg.pend == 2'h0 && !st_reg.tx_req) begin
            st_next.query_pend = 1'b0;
            st_next.pend = 2'h1;
        end
        // unexpected capabilities: 5 V off before the limit
        if (st_reg.off_run && !st_reg.vbus_off) begin
            if (st_reg.otmr >= 32'(PS_OFF_CYC - 2)) begin
                st_next.vbus_off = 1'b1;
            end else begin
                st_next.otmr = st_reg.otmr + 32'h1;
            end
        end
        // transmit
        if (st_reg.tx_req) begin
            if (tx_done) begin
                st_next.tx_req = 1'b0;
            end
        end else if (st_reg.pend != 2'h0) begin
            st_next.tx_req = 1'b1;
            st_next.pend = 2'h0;
            st_next.tx_pdo = pdca_fixed(st_reg.pdo1, 1'b1, st_reg.dual_role,
                st_reg.susp_force);
            case (st_reg.pend)
                2'h1: begin
                    st_next.tx_type = pdca_pkg::MSG_SRC_CAP;
                    st_next.tx_count = st_next.n_obj;
                end
                2'h2: begin
                    st_next.tx_type = pdca_pkg::MSG_SNK_CAP;
                    st_next.tx_count = 3'h1;
                end
                default: begin
                    st_next.tx_type = pdca_pkg::MSG_HARD_RESET;
                    st_next.tx_count = 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.pdo1 <= pdca_pkg::RST_PDO1;
            st_reg.adv <= pdca_pkg::PDCA_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign tx_req = st_reg.tx_req;
    assign tx_type = st_reg.tx_type;
    assign tx_count = st_reg.tx_count;
    assign tx_pdo = st_reg.tx_pdo;
    assign vbus_off = st_reg.vbus_off;

    property p_fixed_type;
        @(posedge pclk) disable iff (!presetn) tx_req |-> tx_pdo[31:30] == 2'h0;
    endproperty
    a_fixed_type: assert property (p_fixed_type) else $error("fixed type wrong");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn) tx_req |-> tx_pdo[24:22] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

    property p_5v_object;
        @(posedge pclk) disable iff (!presetn)
            (tx_req && tx_type == 4'h1) |-> tx_pdo[19:10] == 10'h064;
    endproperty
    a_5v_object: assert property (p_5v_object) else $error("no 5 V object");

    property p_count;
        @(posedge pclk) disable iff (!presetn)
            (tx_req && tx_type == 4'h1) |-> tx_count != 3'h0;
    endproperty
    a_count: assert property (p_count) else $error("empty capabilities");

    property p_susp_zero;
        @(posedge pclk) disable iff (!presetn)
            $rose(tx_req) && st_reg.susp_force |-> tx_pdo[9:0] == 10'h000;
    endproperty
    a_susp_zero: assert property (p_susp_zero) else $error("current not zero");

    property p_drp_flag;
        @(posedge pclk) disable iff (!presetn) tx_req |-> tx_pdo[29] == st_reg.dual_role;
    endproperty
    a_drp_flag: assert property (p_drp_flag) else $error("drp flag mismatch");

    sequence s_snk_query;
        rx_valid && rx_type == 4'h4 && !st_reg.role_src && !st_reg.tx_req;
    endsequence
    property p_snk_reply;
        @(posedge pclk) disable iff (!presetn)
            s_snk_query ##1 !st_reg.tx_req |=> tx_req && tx_type == 4'h4;
    endproperty
    a_snk_reply: assert property (p_snk_reply) else $error("no sink reply");

    property p_no_adv_sink;
        @(posedge pclk) disable iff (!presetn)
            !st_reg.role_src |=> st_reg.adv == pdca_pkg::PDCA_IDLE;
    endproperty
    a_no_adv_sink: assert property (p_no_adv_sink) else $error("sink advertised");

    property p_ack_stops;
        @(posedge pclk) disable iff (!presetn)
            st_reg.adv == pdca_pkg::PDCA_ADV_ACK && rx_goodcrc && st_reg.role_src
            && st_reg.att_s[2] |=> st_reg.adv == pdca_pkg::PDCA_DONE;
    endproperty
    a_ack_stops: assert property (p_ack_stops) else $error("ack ignored");
endmodule

// >>> tb/pdca_peer.sv
// peer protocol controller model: completes transmissions, acknowledges, sends messages
`timescale 1ns/1ps
module pdca_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_req,
    input wire logic [3:0] tx_type,
    input wire logic [7:0] delay,
    input wire logic [7:0] ack_at,
    output logic tx_done,
    output logic rx_goodcrc,
    output logic rx_valid,
    output logic [3:0] rx_type,
    output logic rx_src_cap
);
    int cnt;
    int n_adv;
    logic ack_p;
    initial begin
        rx_valid = 1'b0;
        rx_type = 4'h0;
        rx_src_cap = 1'b0;
    end
    // ack_at of zero never acknowledges; the acknowledgement trails the end by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            n_adv <= 0;
            ack_p <= 1'b0;
            tx_done <= 1'b0;
            rx_goodcrc <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            rx_goodcrc <= ack_p;
            ack_p <= 1'b0;
            if (tx_req && !tx_done) begin
                if (cnt >= int'(delay)) begin
                    tx_done <= 1'b1;
                    cnt <= 0;
                    if (tx_type == pdca_pkg::MSG_SRC_CAP) begin
                        n_adv <= n_adv + 1;
                        ack_p <= (ack_at != 8'h00) && (n_adv + 1 >= int'(ack_at));
                    end
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
    task automatic send(input logic [3:0] t, input logic sc);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_type <= t;
        rx_src_cap <= sc;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_src_cap <= 1'b0;
        // type lines carry the inverted type between messages
        rx_type <= ~t;
    endtask
endmodule

// >>> tb/test_pd_capability_advertiser.sv
// self-checking bench for the capability advertiser
`timescale 1ns/1ps
module test_pd_capability_advertiser;
    localparam int TCYC = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic attach = 1'b0;
    logic vbus_5v = 1'b0;
    logic [7:0] delay = 8'h02;
    logic [7:0] ack_at = 8'h03;
    logic [31:0] prdata, tx_pdo, w, e;
    logic pready, pslverr, rx_valid, rx_src_cap, rx_goodcrc, tx_done, tx_req, vbus_off, prev_req;
    logic [3:0] rx_type, tx_type;
    logic [2:0] tx_count;
    logic [32:0] rd_q[$];
    logic [39:0] tx_q[$];
    logic [39:0] x;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    initial begin
        forever #2 pclk = ~pclk;
    end
    pdca_top #(.SRC_CAP_CYC(TCYC), .SNK_WAIT_CYC(TCYC), .PS_OFF_CYC(TCYC)) i_pdca_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .attach(attach), .vbus_5v(vbus_5v), .rx_valid(rx_valid), .rx_type(rx_type),
        .rx_src_cap(rx_src_cap), .rx_goodcrc(rx_goodcrc), .tx_done(tx_done), .tx_req(tx_req),
        .tx_type(tx_type), .tx_count(tx_count), .tx_pdo(tx_pdo), .vbus_off(vbus_off));
    pdca_peer i_pdca_peer (
        .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_type(tx_type), .delay(delay),
        .ack_at(ack_at), .tx_done(tx_done), .rx_goodcrc(rx_goodcrc), .rx_valid(rx_valid),
        .rx_type(rx_type), .rx_src_cap(rx_src_cap));
    task automatic chk(input logic [32:0] s, input logic [32:0] xp);
        comparisons++;
        if (s !== xp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, s, xp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // read data is only compared on reads; writes carry zero in the data part
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] xp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        rd_q.push_back(xp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic drain(input int c);
        repeat (c) @(posedge pclk);
        chk({32'h0, tx_q.size() == 0}, 33'h1);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && rd_q.size() > 0) begin
            chk({pslverr, pwrite ? 32'h0 : prdata}, rd_q.pop_front());
        end
        if (tx_req === 1'b1 && prev_req !== 1'b1) begin
            if (tx_q.size() == 0) begin
                n_errors++;
                $display("ERROR %0t: unexpected transmission type %h", $time, tx_type);
            end else begin
                x = tx_q.pop_front();
                chk({29'h0, tx_type}, {29'h0, x[35:32]});
                chk({30'h0, tx_count}, {30'h0, x[39:37]});
                if (x[36]) begin
                    chk({1'b0, tx_pdo}, {1'b0, x[31:0]});
                end
            end
        end
        prev_req <= tx_req;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'hD02C));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pdca_pkg::OFS_PDO1, 32'h0, {1'b0, pdca_pkg::RST_PDO1});
        apb(1'b0, pdca_pkg::OFS_STAT, 32'h0, 33'h0);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
        w = $urandom;
        e = {pdca_pkg::TYPE_FIXED, 1'b1, w[28:25], 3'h0, w[21:20], pdca_pkg::VOLT_5V, w[9:0]};
        apb(1'b1, pdca_pkg::OFS_CFG, 32'h3, 33'h0);
        // a second write must not clear the swap flag
        apb(1'b1, pdca_pkg::OFS_CFG, 32'h0, 33'h0);
        apb(1'b0, pdca_pkg::OFS_CFG, 32'h0, 33'h3);
        apb(1'b1, pdca_pkg::OFS_PDO1, w, 33'h0);
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h1, 33'h0);
        repeat (3) tx_q.push_back({3'h1, 1'b1, pdca_pkg::MSG_SRC_CAP, e});
        attach <= 1'b1;
        drain(8 * TCYC);
        tx_q.push_back({3'h1, 1'b1, pdca_pkg::MSG_SRC_CAP, e[31:10], pdca_pkg::CURR_0MA});
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h19, 33'h0);
        drain(3 * TCYC);
        // the reserve adds a second object to the count
        tx_q.push_back({3'h2, 1'b1, pdca_pkg::MSG_SRC_CAP, e});
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h15, 33'h0);
        drain(3 * TCYC);
        apb(1'b0, pdca_pkg::OFS_HDR, 32'h0, 33'h2);
        tx_q.push_back({3'h1, 1'b1, pdca_pkg::MSG_SRC_CAP, e});
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h1, 33'h0);
        drain(3 * TCYC);
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h1, 33'h0);
        drain(3 * TCYC);
        delay <= 8'h0F;
        tx_q.push_back({3'h1, 1'b1, pdca_pkg::MSG_SRC_CAP, e});
        i_pdca_peer.send(4'h2, 1'b0);
        drain(3 * TCYC);
        tx_q.push_back({3'h1, 1'b0, pdca_pkg::MSG_SNK_CAP, 32'h0});
        i_pdca_peer.send(4'h4, 1'b0);
        drain(3 * TCYC);
        i_pdca_peer.send(pdca_pkg::MSG_SRC_CAP, 1'b1);
        n = 0;
        while (vbus_off !== 1'b1 && n < TCYC + 8) begin
            @(posedge pclk);
            n++;
        end
        chk({32'h0, vbus_off}, 33'h1);
        drain(TCYC);
        presetn <= 1'b0;
        attach <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, pdca_pkg::OFS_CTRL, 32'h2, 33'h0);
        attach <= 1'b1;
        // a sink-only port stays silent on a goto-min message
        i_pdca_peer.send(4'h2, 1'b0);
        drain(3 * TCYC);
        tx_q.push_back({3'h1, 1'b0, pdca_pkg::MSG_SNK_CAP, 32'h0});
        i_pdca_peer.send(4'h4, 1'b0);
        drain(3 * TCYC);
        vbus_5v <= 1'b1;
        repeat (6) begin
            repeat (TCYC / 2) @(posedge pclk);
            i_pdca_peer.send(pdca_pkg::MSG_SRC_CAP, 1'b1);
        end
        tx_q.push_back({3'h0, 1'b0, pdca_pkg::MSG_HARD_RESET, 32'h0});
        n = 0;
        while (tx_req !== 1'b1 && n < 4 * TCYC) begin
            @(posedge pclk);
            n++;
        end
        // drop 5 V so the wait timer cannot fire a second time
        vbus_5v <= 1'b0;
        drain(3 * TCYC);
        finish_test();
    end
endmodule
